//--- hw/ieee_status_map.vh
// Constants for the status-reporting block: command codes, bit positions, reset values
`ifndef IEEE_STATUS_MAP_VH
`define IEEE_STATUS_MAP_VH

// ****************************************************
// Command codes presented on cmd_code_i
// ****************************************************
`define ISR_CMD_CLS     4'h0
`define ISR_CMD_ESE     4'h1
`define ISR_CMD_ESE_Q   4'h2
`define ISR_CMD_SRE     4'h3
`define ISR_CMD_SRE_Q   4'h4
`define ISR_CMD_ESR_Q   4'h5
`define ISR_CMD_STB_Q   4'h6
`define ISR_CMD_OPC     4'h7
`define ISR_CMD_OPC_Q   4'h8
`define ISR_CMD_TST_Q   4'h9

// ****************************************************
// Standard event status bit positions
// ****************************************************
`define ISR_ESR_PON     7
`define ISR_ESR_URQ     6
`define ISR_ESR_CME     5
`define ISR_ESR_EXE     4
`define ISR_ESR_DDE     3
`define ISR_ESR_QYE     2
`define ISR_ESR_RQC     1
`define ISR_ESR_OPC     0

// ****************************************************
// Status byte bit positions
// ****************************************************
`define ISR_STB_OSS     7
`define ISR_STB_RQS     6
`define ISR_STB_ESB     5
`define ISR_STB_MAV     4

// ****************************************************
// Reset values and fixed answers
// ****************************************************
`define ISR_ESR_RESET   8'h80
`define ISR_MASK_RESET  8'h00
`define ISR_ZERO_BYTE   8'h00
`define ISR_LOW_NIBBLE  4'h0
`define ISR_OPC_ANSWER  8'h01
`define ISR_ONE_DIGIT   2'h1

`endif

//--- hw/ieee_status_core.v
// Status-reporting register bank: event status, enables, status byte and common queries
`include "ieee_status_map.vh"

module isr_status_core #(
	parameter DW = 8 // Width of every status register
) (
	input wire clock_i, // System clock, 40 MHz
	input wire rstn_i, // Synchronous reset, active low
	input wire cmd_valid_i, // One-cycle command strobe
	input wire [3:0] cmd_code_i, // Command code
	input wire [DW-1:0] cmd_value_i, // Decoded NR1 argument
	input wire [DW-1:1] event_i, // Event pulses for bits 7..1
	input wire meas_busy_i, // High while measurements pending
	input wire oper_summary_i, // Operation status summary level
	input wire msg_avail_i, // Output queue holds a message
	input wire test_done_i, // Self-test finished pulse
	input wire [DW-1:0] test_errsum_i, // Sum of self-test error codes
	output reg cmd_ready_o, // Low while a query waits
	output reg reply_valid_o, // One-cycle answer strobe
	output reg [DW-1:0] reply_value_o, // Answer as a binary value
	output reg [11:0] reply_bcd_o, // Answer as three decimal digits
	output reg [1:0] reply_ndig_o, // Significant digit count
	output reg test_start_o, // Self-test launch pulse
	output reg srq_o, // Request-service level
	output reg [DW-1:0] ese_o, // Event enable mask
	output reg [DW-1:0] sre_o, // Service enable mask
	output reg [DW-1:0] esr_o, // Event status register
	output reg [DW-1:0] stb_o // Status byte
);

	// ****************************************************
	// States, one-hot
	// ****************************************************
	localparam [2:0] ST_IDLE = 3'b001; // Accepting commands
	localparam [2:0] ST_WOPC = 3'b010; // Waiting for idle to answer
	localparam [2:0] ST_WTST = 3'b100; // Waiting for self-test

	reg [2:0] state_reg; // Current state
	reg [2:0] state_next; // Next state
	reg opc_arm_reg; // Completion bit armed
	reg opc_arm_next; // Next arm value
	reg [DW-1:0] esr_next; // Next event status
	reg [DW-1:0] ese_next; // Next event mask
	reg [DW-1:0] sre_next; // Next service mask
	reg [DW-1:0] stb_next; // Next status byte
	reg rep_next; // Answer strobe next
	reg [DW-1:0] rep_val_next; // Answer value next
	reg tst_next; // Self-test launch next
	reg [DW-1:0] set_bits; // Bits set this cycle
	reg esb; // Event summary

	// ****************************************************
	// Helpers
	// ****************************************************
	// Binary byte to three packed decimal digits
	function [11:0] to_bcd;
		input [7:0] v;
		reg [7:0] hun; // Hundreds digit
		reg [7:0] ten; // Tens digit
		reg [7:0] one; // Units digit
		begin
			hun = v / 8'h64;
			ten = (v / 8'h0a) % 8'h0a;
			one = v % 8'h0a;
			// Each digit fits one nibble, so only the low nibble is kept
			to_bcd = {hun[3:0], ten[3:0], one[3:0]};
		end
	endfunction

	// Digits needed to print a byte in decimal
	function [1:0] ndig;
		input [7:0] v;
		begin
			if (v >= 8'h64) begin
				ndig = 2'h3;
			end else if (v >= 8'h0a) begin
				ndig = 2'h2;
			end else begin
				ndig = `ISR_ONE_DIGIT;
			end
		end
	endfunction

	// ****************************************************
	// Next-state logic
	// ****************************************************
	always @* begin
		state_next = state_reg;
		opc_arm_next = opc_arm_reg;
		ese_next = ese_o;
		sre_next = sre_o;
		esr_next = esr_o;
		rep_next = 1'b0;
		rep_val_next = `ISR_ZERO_BYTE;
		tst_next = 1'b0;
		set_bits = {event_i, 1'b0}; // Hardware events, layout fixed
		// Armed completion fires once measurements are done
		if (opc_arm_reg && !meas_busy_i) begin
			set_bits[`ISR_ESR_OPC] = 1'b1;
			opc_arm_next = 1'b0;
		end
		case (state_reg)
			ST_IDLE: begin
				if (cmd_valid_i) begin
					case (cmd_code_i)
						`ISR_CMD_CLS: begin
							esr_next = `ISR_ZERO_BYTE;
							opc_arm_next = 1'b0;
						end
						`ISR_CMD_ESE: begin
							ese_next = cmd_value_i;
						end
						`ISR_CMD_ESE_Q: begin
							rep_next = 1'b1;
							rep_val_next = ese_o;
						end
						`ISR_CMD_SRE: begin
							sre_next = cmd_value_i;
						end
						`ISR_CMD_SRE_Q: begin
							rep_next = 1'b1;
							rep_val_next = sre_o;
						end
						`ISR_CMD_ESR_Q: begin
							rep_next = 1'b1;
							rep_val_next = esr_o;
							esr_next = `ISR_ZERO_BYTE;
						end
						`ISR_CMD_STB_Q: begin
							rep_next = 1'b1;
							rep_val_next = stb_o;
						end
						`ISR_CMD_OPC: begin
							opc_arm_next = 1'b1;
						end
						`ISR_CMD_OPC_Q: begin
							state_next = ST_WOPC;
						end
						`ISR_CMD_TST_Q: begin
							tst_next = 1'b1;
							state_next = ST_WTST;
						end
						default: begin
							// Unknown codes are ignored
						end
					endcase
				end
			end
			ST_WOPC: begin
				// Answer binary one (8'h01) only when nothing is pending
				if (!meas_busy_i) begin
					rep_next = 1'b1;
					rep_val_next = `ISR_OPC_ANSWER;
					state_next = ST_IDLE;
				end
			end
			ST_WTST: begin
				// Error sum is zero for a clean test
				if (test_done_i) begin
					rep_next = 1'b1;
					rep_val_next = test_errsum_i;
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
		// A set arriving with a clear still lands
		esr_next = esr_next | set_bits;
		// Status byte follows the new register contents
		esb = |(esr_next & ese_next);
		stb_next = `ISR_ZERO_BYTE;
		stb_next[`ISR_STB_OSS] = oper_summary_i;
		stb_next[`ISR_STB_ESB] = esb;
		stb_next[`ISR_STB_MAV] = msg_avail_i;
		stb_next[3:0] = `ISR_LOW_NIBBLE;
		// Request service ignores its own enable bit: that bit is still clear here
		stb_next[`ISR_STB_RQS] = |(stb_next & sre_next);
	end

	// ****************************************************
	// Registers
	// ****************************************************
	always @(posedge clock_i) begin
		if (!rstn_i) begin
			state_reg <= ST_IDLE;
			opc_arm_reg <= 1'b0;
			ese_o <= `ISR_MASK_RESET;
			sre_o <= `ISR_MASK_RESET;
			esr_o <= `ISR_ESR_RESET; // Power-on bit set
			stb_o <= `ISR_ZERO_BYTE;
			srq_o <= 1'b0;
			cmd_ready_o <= 1'b0;
			reply_valid_o <= 1'b0;
			reply_value_o <= `ISR_ZERO_BYTE;
			reply_bcd_o <= 12'h000;
			reply_ndig_o <= 2'h0;
			test_start_o <= 1'b0;
		end else begin
			state_reg <= state_next;
			opc_arm_reg <= opc_arm_next;
			ese_o <= ese_next;
			sre_o <= sre_next;
			esr_o <= esr_next;
			stb_o <= stb_next;
			srq_o <= stb_next[`ISR_STB_RQS];
			cmd_ready_o <= (state_next == ST_IDLE);
			reply_valid_o <= rep_next;
			reply_value_o <= rep_val_next;
			reply_bcd_o <= to_bcd(rep_val_next);
			reply_ndig_o <= ndig(rep_val_next);
			test_start_o <= tst_next;
		end
	end

endmodule

//--- bench/isr_chk_assertions.sv
// Port checks for the status block
`include "ieee_status_map.vh"
module isr_chk (
	input wire clock_i,
	input wire rstn_i,
	input wire cmd_valid_i,
	input wire [3:0] cmd_code_i,
	input wire [7:0] cmd_value_i,
	input wire [7:1] event_i,
	input wire meas_busy_i,
	input wire cmd_ready_o,
	input wire reply_valid_o,
	input wire [7:0] reply_value_o,
	input wire test_start_o,
	input wire srq_o,
	input wire [7:0] ese_o,
	input wire [7:0] sre_o,
	input wire [7:0] esr_o,
	input wire [7:0] stb_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// Command taken this edge
	wire acc = cmd_valid_i && cmd_ready_o;
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rstn_i);
	a_low_zero: assert property (stb_o[3:0] == 4'h0) else $error("low nibble set");
	a_esb_sum: assert property (stb_o[5] == |(esr_o & ese_o)) else $error("summary bad");
	a_rqs_sum: assert property (srq_o == |(stb_o & sre_o & 8'hb0)) else $error("request bad");
	a_ese_wr: assert property (acc && cmd_code_i == `ISR_CMD_ESE |=> ese_o == $past(cmd_value_i))
		else $error("mask write");
	a_ese_rd: assert property (acc && cmd_code_i == `ISR_CMD_ESE_Q
		|=> reply_valid_o && reply_value_o == $past(ese_o)) else $error("mask read");
	a_sre_rd: assert property (acc && cmd_code_i == `ISR_CMD_SRE_Q
		|=> reply_valid_o && reply_value_o == $past(sre_o)) else $error("service read");
	a_esr_rd: assert property (acc && cmd_code_i == `ISR_CMD_ESR_Q |=> reply_value_o == $past(esr_o))
		else $error("event read");
	a_stb_rd: assert property (acc && cmd_code_i == `ISR_CMD_STB_Q
		|=> reply_value_o == $past(stb_o) && $stable(stb_o)) else $error("byte read");
	a_opc_rd: assert property (acc && cmd_code_i == `ISR_CMD_OPC_Q ##1 !meas_busy_i
		|=> reply_valid_o && reply_value_o == 1) else $error("done answer");
	a_tst_go: assert property (acc && cmd_code_i == `ISR_CMD_TST_Q |=> test_start_o && !cmd_ready_o)
		else $error("test start");
	a_cls_clr: assert property (acc && cmd_code_i == `ISR_CMD_CLS && event_i == 0 |=> esr_o[7:1] == 0)
		else $error("clear");
endmodule
bind isr_status_core isr_chk isr_chk_i (.*);

//--- bench/isr_host.sv
// Host controller model issuing common commands
module isr_host (
	input wire clock_i,
	input wire ready_i,
	output logic valid_o = 0,
	output logic [3:0] code_o = 0,
	output logic [7:0] value_o = 0,
	output logic tmo_o = 0
);
	timeunit 1ns;
	timeprecision 100ps;
	// Present a command and hold it until taken, for at most 64 cycles
	task send(input [3:0] c, input [7:0] v);
		integer k;
		begin
			k = 0;
			@(posedge clock_i);
			valid_o <= 1'b1;
			code_o <= c;
			value_o <= v;
			do begin
				@(posedge clock_i);
				k = k + 1;
			end while (ready_i !== 1'b1 && k < 64);
			if (ready_i !== 1'b1) tmo_o = 1'b1;
			valid_o <= 1'b0;
			// Released argument turns over so stale data is not reused
			value_o <= ~v;
		end
	endtask
endmodule

//--- bench/tb_ieee4882_status_reporting.sv
// Self-checking bench of the status block
`include "ieee_status_map.vh"
module tb_ieee4882_status_reporting;
	timeunit 1ns;
	timeprecision 100ps;
	reg clock_i = 0;
	reg rstn_i = 0;
	reg [7:1] event_i = 0;
	reg meas_busy_i = 0, oper_summary_i = 0, msg_avail_i = 0, test_done_i = 0;
	reg [7:0] test_errsum_i = 0, v, e, r, s;
	wire [11:0] reply_bcd_o;
	wire [1:0] reply_ndig_o;
	wire cmd_valid_i, cmd_ready_o, reply_valid_o, test_start_o, srq_o, tmo;
	wire [3:0] cmd_code_i;
	wire [7:0] cmd_value_i, reply_value_o, ese_o, sre_o, esr_o, stb_o;
	integer num_errors = 0, n_tests = 0, seed = 32'h08fd_b821, i;
	isr_host isr_host_i (.clock_i(clock_i), .ready_i(cmd_ready_o), .valid_o(cmd_valid_i), .code_o(cmd_code_i),
		.value_o(cmd_value_i), .tmo_o(tmo));
	isr_status_core isr_status_core_i (.clock_i(clock_i), .rstn_i(rstn_i), .cmd_valid_i(cmd_valid_i),
		.cmd_code_i(cmd_code_i), .cmd_value_i(cmd_value_i), .event_i(event_i), .meas_busy_i(meas_busy_i),
		.oper_summary_i(oper_summary_i), .msg_avail_i(msg_avail_i), .test_done_i(test_done_i),
		.test_errsum_i(test_errsum_i), .cmd_ready_o(cmd_ready_o), .reply_valid_o(reply_valid_o),
		.reply_value_o(reply_value_o), .reply_bcd_o(reply_bcd_o), .reply_ndig_o(reply_ndig_o), .test_start_o(test_start_o),
		.srq_o(srq_o), .ese_o(ese_o), .sre_o(sre_o), .esr_o(esr_o), .stb_o(stb_o));
	initial begin
		forever #12.5 clock_i = ~clock_i;
	end
	task check(input [11:0] got, input [11:0] exp);
		begin
			n_tests = n_tests + 1;
			if (got !== exp) begin
				num_errors = num_errors + 1;
				$display("BAD %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task end_sim;
		begin
			$display("tests %0d errors %0d", n_tests, num_errors);
			if (num_errors == 0 && n_tests > 0) $display("== PASSED ==");
			else $display("== FAILED ==");
			$finish;
		end
	endtask
	// Decimal digits of a byte, hundreds first
	function [11:0] dec3(input [7:0] x);
		begin
			dec3 = (x / 100) * 256 + ((x / 10) % 10) * 16 + x % 10;
		end
	endfunction
	// Count of significant decimal digits
	function [1:0] ndig3(input [7:0] x);
		begin
			ndig3 = (x > 8'h63) ? 2'h3 : (x > 8'h09) ? 2'h2 : 2'h1;
		end
	endfunction
	// Wait for the answer strobe, bounded
	task get(output [7:0] val);
		integer k;
		begin
			k = 0;
			do begin
				@(posedge clock_i);
				k = k + 1;
			end while (reply_valid_o !== 1'b1 && k < 64);
			if (reply_valid_o !== 1'b1) check(8'h00, 8'hff);
			val = reply_value_o;
			check(reply_bcd_o, dec3(reply_value_o));
			check({10'h000, reply_ndig_o}, {10'h000, ndig3(reply_value_o)});
		end
	endtask
	task q(input [3:0] c);
		begin
			isr_host_i.send(c, 8'h00);
			get(r);
		end
	endtask
	// Expected status byte from event bits and masks
	function [7:0] exp_stb(input [7:0] es, input [7:0] en, input [7:0] sr);
		reg b5;
		begin
			b5 = |(es & en);
			exp_stb = {oper_summary_i, |({oper_summary_i, b5, msg_avail_i} & {sr[7], sr[5], sr[4]}), b5, msg_avail_i, 4'h0};
		end
	endfunction
	initial begin
		repeat (5) @(posedge clock_i);
		rstn_i <= 1;
		q(`ISR_CMD_ESR_Q);
		check(r, 8'h80);
		q(`ISR_CMD_ESR_Q);
		check(r, 8'h00);
		for (i = 0; i < 8; i = i + 1) begin
			v = $random(seed);
			e = $random(seed);
			isr_host_i.send(`ISR_CMD_ESE, v);
			isr_host_i.send(`ISR_CMD_SRE, e);
			oper_summary_i <= v[0];
			msg_avail_i <= e[0];
			event_i <= e[7:1];
			@(posedge clock_i);
			event_i <= 7'h00;
			q(`ISR_CMD_ESE_Q);
			check(r, v);
			q(`ISR_CMD_SRE_Q);
			check(r, e);
			s = exp_stb({e[7:1], 1'b0}, v, e);
			check(ese_o, v);
			check(sre_o, e);
			check(esr_o, {e[7:1], 1'b0});
			check(stb_o, s);
			check({7'h00, srq_o}, {7'h00, s[6]});
			repeat (2) begin
				q(`ISR_CMD_STB_Q);
				check(r, s);
			end
			q(`ISR_CMD_ESR_Q);
			check(r, {e[7:1], 1'b0});
		end
		event_i <= 7'h7f;
		@(posedge clock_i);
		event_i <= 7'h00;
		isr_host_i.send(`ISR_CMD_CLS, 8'h00);
		q(`ISR_CMD_ESR_Q);
		check(r, 8'h00);
		meas_busy_i <= 1;
		isr_host_i.send(`ISR_CMD_OPC, 8'h00);
		q(`ISR_CMD_ESR_Q);
		check(r, 8'h00);
		meas_busy_i <= 0;
		repeat (2) @(posedge clock_i);
		q(`ISR_CMD_ESR_Q);
		check(r, 8'h01);
		meas_busy_i <= 1;
		isr_host_i.send(`ISR_CMD_OPC_Q, 8'h00);
		repeat (4) @(posedge clock_i);
		check({7'h00, cmd_ready_o}, 8'h00);
		meas_busy_i <= 0;
		get(r);
		check(r, 8'h01);
		isr_host_i.send(`ISR_CMD_TST_Q, 8'h00);
		@(posedge clock_i);
		check({7'h00, test_start_o}, 8'h01);
		test_errsum_i <= v;
		test_done_i <= 1;
		@(posedge clock_i);
		test_done_i <= 0;
		get(r);
		check(r, v);
		check({7'h00, tmo}, 8'h00);
		end_sim;
	end
endmodule
